// ==== hdl/eacc_consts.svh ====
// constants of the apparent energy accumulator
// How it works
// RULE1: adds apparent power into hidden 49-bit accumulator
// RULE2: accumulation uses signed addition
// RULE3: one accumulation step every 12 clocks
// RULE4: energy register is upper 24 divided bits
// RULE5: 8-bit divider, zero means divide by one
// RULE6: second energy register clears on each read
// RULE7: positive overflow wraps to full-scale negative
// RULE8: half-full energy raises enabled interrupt
// RULE9: line-cycle accumulation always runs
// RULE10: measurement mode bits 4-6 pick phases
// RULE11: 16-bit half cycle count sets period
// RULE12: period end sets flag, enabled irq low
// RULE13: combination mode and term selects build total
// RULE14: line energy shares continuous path weight; the line watt channel always divides by one
// RULE15: waveform bit 5 selects reactive energy mode
// RULE16: reactive mode active energy added unsigned
// RULE17: reactive mode uses line watt term selects
// RULE18: combination mode is bits 7:6
// RULE19: line accumulation restarts each period, latched end
`ifndef EACC_CONSTS_SVH
`define EACC_CONSTS_SVH

`define EACC_ACC_W          49
`define EACC_E_W            24
`define EACC_PWR_W          24
`define EACC_RMS_W          16
`define EACC_ADDR_W         6
`define EACC_TICK_CYCLES    12
`define EACC_TICK_LAST      4'((`EACC_TICK_CYCLES) - 1)

// register addresses
`define EACC_A_MEAS_MODE    6'h0B
`define EACC_A_WAV_MODE     6'h0C
`define EACC_A_ENERGY       6'h14
`define EACC_A_ENERGY_RC    6'h15
`define EACC_A_DIVIDER      6'h16
`define EACC_A_HALF_CYC     6'h17
`define EACC_A_VA_MODE      6'h18
`define EACC_A_WAT_MODE     6'h19
`define EACC_A_LINE_VA      6'h1A
`define EACC_A_LINE_W       6'h1B
`define EACC_A_IRQ_EN       6'h1C
`define EACC_A_IRQ_ST       6'h1D

// field positions
`define EACC_MM_ZX_LO       4
`define EACC_WM_REACT       5
`define EACC_VM_SEL_LO      0
`define EACC_VM_LSEL_LO     3
`define EACC_VM_MOD_LO      6
`define EACC_WT_LSEL_LO     3
`define EACC_IRQ_HALF       0
`define EACC_IRQ_LINE       1

// combination modes
`define EACC_MOD_WYE        2'h0
`define EACC_MOD_AVG        2'h1
`define EACC_MOD_DELTA      2'h2

// reset values
`define EACC_RST_BYTE       8'h00
`define EACC_RST_HALF_CYC   16'hFFFF

// accumulator channels
`define EACC_CH_CONT        0
`define EACC_CH_RC          1
`define EACC_CH_LVA         2
`define EACC_CH_LW          3
`define EACC_NCH            4

`endif

// ==== hdl/eacc_pkg.sv ====
// state types of the apparent energy accumulator
`include "eacc_consts.svh"
package eacc_pkg;

  typedef struct packed {
    logic [`EACC_ACC_W-1:0] acc;
  } eacc_acc_s;

  typedef struct packed {
    logic [3:0]             tick_cnt;
    logic [7:0]             meas_mode;
    logic [7:0]             wav_mode;
    logic [7:0]             va_mode;
    logic [7:0]             wat_mode;
    logic [7:0]             divider;
    logic [15:0]            half_cyc;
    logic [15:0]            hc_seen;
    logic [7:0]             irq_en;
    logic [7:0]             irq_st;
    logic                   half_prev;
    logic [`EACC_E_W-1:0]   line_va;
    logic [`EACC_E_W-1:0]   line_w;
    logic [`EACC_E_W-1:0]   rdata;
    logic                   irq_n;
    logic [2:0]             zx_en;
  } eacc_main_s;

endpackage : eacc_pkg

// ==== hdl/eacc_acc_if.sv ====
// carrier between the controller and one accumulator channel
`timescale 1ns/10ps
`include "eacc_consts.svh"
interface eacc_acc_if;
  logic                          tick;
  logic                          clr;
  logic signed [`EACC_ACC_W-1:0] addend;
  logic [7:0]                    div;
  logic [`EACC_E_W-1:0]          energy;

  modport ctrl (output tick, output clr, output addend, output div, input energy);
  modport acc  (input tick, input clr, input addend, input div, output energy);
endinterface : eacc_acc_if

// ==== hdl/eacc_accum.sv ====
// one wide signed accumulator with divided 24-bit view
`timescale 1ns/10ps
`include "eacc_consts.svh"
module eacc_accum (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // controller side
  eacc_acc_if.acc   acc_if
);

  eacc_pkg::eacc_acc_s r_r;
  eacc_pkg::eacc_acc_s r_nxt;
  logic signed [`EACC_ACC_W:0] quot;
  logic        [7:0]           div_eff;

  always_comb begin
    r_nxt = r_r;
    // clear and add in one cycle keeps the arriving sample
    if (acc_if.clr) begin
      r_nxt.acc = '0;
    end
    if (acc_if.tick) begin
      r_nxt.acc = r_nxt.acc + acc_if.addend; // RULE1 RULE2 RULE7
    end
  end

  always_comb begin
    div_eff = (acc_if.div == 8'h00) ? 8'h01 : acc_if.div; // RULE5
    quot    = $signed({r_r.acc[`EACC_ACC_W-1], r_r.acc})
              / $signed({{(`EACC_ACC_W-8){1'b0}}, div_eff});
  end

  // upper bits of the divided value, wrapping with the accumulator
  assign acc_if.energy = quot[`EACC_ACC_W-1 -: `EACC_E_W]; // RULE4

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule : eacc_accum

// ==== hdl/eacc_top.sv ====
// apparent energy accumulation with line-cycle mode and register port
`timescale 1ns/10ps
`include "eacc_consts.svh"
module eacc_top (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          reset_n_i,
  // register port
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [`EACC_ADDR_W-1:0]       reg_addr_i,
  input  wire logic [`EACC_E_W-1:0]          reg_wdata_i,
  output logic      [`EACC_E_W-1:0]          reg_rdata_o,
  // per-phase measurements, phase a in index 0
  input  wire logic [2:0][`EACC_RMS_W-1:0]   vrms_i,
  input  wire logic [2:0][`EACC_RMS_W-1:0]   irms_i,
  input  wire logic [2:0][`EACC_PWR_W-1:0]   active_pwr_i,
  input  wire logic [2:0][`EACC_PWR_W-1:0]   reactive_pwr_i,
  input  wire logic [2:0]                    zero_cross_i,
  // status
  output logic      [2:0]                    zx_enable_o,
  output logic                               irq_n_o
);

  localparam int PW = 2 * `EACC_RMS_W + 1;

  eacc_pkg::eacc_main_s r_r;
  eacc_pkg::eacc_main_s r_nxt;

  eacc_acc_if acc_if [`EACC_NCH] ();

  logic                          tick;
  logic [1:0]                    va_mod;
  logic [2:0]                    va_sel;
  logic [2:0]                    lva_sel;
  logic [2:0]                    lw_sel;
  logic                          react;
  logic [2:0][PW-1:0]            va_term;
  logic [`EACC_RMS_W:0]          v_avg;
  logic signed [`EACC_ACC_W-1:0] va_sum;
  logic signed [`EACC_ACC_W-1:0] lva_sum;
  logic signed [`EACC_ACC_W-1:0] w_sum_s;
  logic signed [`EACC_ACC_W-1:0] w_sum_u;
  logic signed [`EACC_ACC_W-1:0] q_sum;
  logic [1:0]                    zx_cnt;
  logic [16:0]                   hc_next;
  logic                          line_end;
  logic                          half_now;
  logic                          rd_rc;
  logic                          rd_st;
  logic [`EACC_E_W-1:0]          rd_mux;
  logic [7:0]                    st_set;

  always_comb begin
    tick    = (r_r.tick_cnt == `EACC_TICK_LAST); // RULE3
    va_mod  = r_r.va_mode[`EACC_VM_MOD_LO +: 2]; // RULE18
    va_sel  = r_r.va_mode[`EACC_VM_SEL_LO +: 3];
    lva_sel = r_r.va_mode[`EACC_VM_LSEL_LO +: 3];
    lw_sel  = r_r.wat_mode[`EACC_WT_LSEL_LO +: 3];
    react   = r_r.wav_mode[`EACC_WM_REACT]; // RULE15
    v_avg   = ({1'b0, vrms_i[0]} + {1'b0, vrms_i[2]}) >> 1;
    va_term[0] = PW'(vrms_i[0] * irms_i[0]);
    va_term[2] = PW'(vrms_i[2] * irms_i[2]);
    // middle term depends on the wiring of the service
    case (va_mod) // RULE13
      `EACC_MOD_AVG:   va_term[1] = PW'(v_avg * irms_i[1]);
      `EACC_MOD_DELTA: va_term[1] = PW'(vrms_i[0] * irms_i[1]);
      default:         va_term[1] = PW'(vrms_i[1] * irms_i[1]);
    endcase
    va_sum  = '0;
    lva_sum = '0;
    w_sum_s = '0;
    w_sum_u = '0;
    q_sum   = '0;
    for (int p = 0; p < 3; p++) begin
      if (va_sel[p]) begin
        va_sum = va_sum + `EACC_ACC_W'(va_term[p]); // RULE13
      end
      if (lva_sel[p]) begin
        lva_sum = lva_sum + `EACC_ACC_W'(va_term[p]); // RULE13
      end
      if (lw_sel[p]) begin
        w_sum_s = w_sum_s + `EACC_ACC_W'($signed(active_pwr_i[p]));
        w_sum_u = w_sum_u + `EACC_ACC_W'(active_pwr_i[p]); // RULE16
        q_sum   = q_sum + `EACC_ACC_W'($signed(reactive_pwr_i[p])); // RULE17
      end
    end
  end

  // half cycle counting over the enabled phases
  always_comb begin
    zx_cnt = 2'h0;
    for (int p = 0; p < 3; p++) begin
      zx_cnt = zx_cnt + 2'(zero_cross_i[p] & r_r.zx_en[p]); // RULE10
    end
    hc_next  = {1'b0, r_r.hc_seen} + {15'h0, zx_cnt};
    // a zero count never closes a period
    line_end = (zx_cnt != 2'h0) && (r_r.half_cyc != 16'h0000)
               && (hc_next >= {1'b0, r_r.half_cyc}); // RULE11
  end

  // channel drive: all channels share one tick; the line channels take their own addends
  assign acc_if[`EACC_CH_CONT].tick   = tick; // RULE1
  assign acc_if[`EACC_CH_CONT].clr    = 1'b0;
  assign acc_if[`EACC_CH_CONT].addend = va_sum;
  assign acc_if[`EACC_CH_CONT].div    = r_r.divider; // RULE5
  assign acc_if[`EACC_CH_RC].tick     = tick;
  assign acc_if[`EACC_CH_RC].clr      = rd_rc; // RULE6
  assign acc_if[`EACC_CH_RC].addend   = va_sum;
  assign acc_if[`EACC_CH_RC].div      = r_r.divider;
  assign acc_if[`EACC_CH_LVA].tick    = tick; // RULE9
  assign acc_if[`EACC_CH_LVA].clr     = line_end; // RULE19
  assign acc_if[`EACC_CH_LVA].addend  = react ? w_sum_u : lva_sum; // RULE15 RULE16
  assign acc_if[`EACC_CH_LVA].div     = r_r.divider; // RULE14
  assign acc_if[`EACC_CH_LW].tick     = tick;
  assign acc_if[`EACC_CH_LW].clr      = line_end;
  assign acc_if[`EACC_CH_LW].addend   = react ? q_sum : w_sum_s; // RULE15
  assign acc_if[`EACC_CH_LW].div      = 8'h00;

  genvar ch;
  generate
    for (ch = 0; ch < `EACC_NCH; ch++) begin : g_ch
      eacc_accum u_acc (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .acc_if    (acc_if[ch])
      );
    end
  endgenerate

  // register reads
  always_comb begin
    rd_rc = reg_rd_i && (reg_addr_i == `EACC_A_ENERGY_RC);
    rd_st = reg_rd_i && (reg_addr_i == `EACC_A_IRQ_ST);
    case (reg_addr_i)
      `EACC_A_MEAS_MODE: rd_mux = {16'h0000, r_r.meas_mode};
      `EACC_A_WAV_MODE:  rd_mux = {16'h0000, r_r.wav_mode};
      `EACC_A_ENERGY:    rd_mux = acc_if[`EACC_CH_CONT].energy;
      `EACC_A_ENERGY_RC: rd_mux = acc_if[`EACC_CH_RC].energy;
      `EACC_A_DIVIDER:   rd_mux = {16'h0000, r_r.divider};
      `EACC_A_HALF_CYC:  rd_mux = {8'h00, r_r.half_cyc};
      `EACC_A_VA_MODE:   rd_mux = {16'h0000, r_r.va_mode};
      `EACC_A_WAT_MODE:  rd_mux = {16'h0000, r_r.wat_mode};
      `EACC_A_LINE_VA:   rd_mux = r_r.line_va;
      `EACC_A_LINE_W:    rd_mux = r_r.line_w;
      `EACC_A_IRQ_EN:    rd_mux = {16'h0000, r_r.irq_en};
      `EACC_A_IRQ_ST:    rd_mux = {16'h0000, r_r.irq_st};
      default:           rd_mux = 24'h000000;
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.tick_cnt = tick ? 4'h0 : r_r.tick_cnt + 4'h1; // RULE3
    // half full in either sign: top two bits differ
    half_now = acc_if[`EACC_CH_CONT].energy[`EACC_E_W-1]
               ^ acc_if[`EACC_CH_CONT].energy[`EACC_E_W-2];
    r_nxt.half_prev = half_now;
    st_set = 8'h00;
    st_set[`EACC_IRQ_HALF] = half_now & ~r_r.half_prev; // RULE8
    st_set[`EACC_IRQ_LINE] = line_end; // RULE12
    if (reg_wr_i) begin
      case (reg_addr_i)
        `EACC_A_MEAS_MODE: r_nxt.meas_mode = reg_wdata_i[7:0];
        `EACC_A_WAV_MODE:  r_nxt.wav_mode  = reg_wdata_i[7:0];
        `EACC_A_DIVIDER:   r_nxt.divider   = reg_wdata_i[7:0];
        `EACC_A_HALF_CYC:  r_nxt.half_cyc  = reg_wdata_i[15:0];
        `EACC_A_VA_MODE:   r_nxt.va_mode   = reg_wdata_i[7:0];
        `EACC_A_WAT_MODE:  r_nxt.wat_mode  = reg_wdata_i[7:0];
        `EACC_A_IRQ_EN:    r_nxt.irq_en    = reg_wdata_i[7:0];
        default:           r_nxt.tick_cnt  = r_nxt.tick_cnt;
      endcase
    end
    r_nxt.zx_en = r_nxt.meas_mode[`EACC_MM_ZX_LO +: 3]; // RULE10
    // a new event in the clearing read survives
    r_nxt.irq_st = (rd_st ? 8'h00 : r_r.irq_st) | st_set;
    r_nxt.irq_n  = ~|(r_nxt.irq_st & r_nxt.irq_en); // RULE8 RULE12
    if (zx_cnt != 2'h0) begin
      r_nxt.hc_seen = line_end ? 16'h0000 : hc_next[15:0]; // RULE19
    end
    if (line_end) begin
      r_nxt.line_va = acc_if[`EACC_CH_LVA].energy; // RULE19
      r_nxt.line_w  = acc_if[`EACC_CH_LW].energy;
    end
    if (reg_rd_i) begin
      r_nxt.rdata = rd_mux; // RULE6
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r           <= '0;
      r_r.half_cyc  <= `EACC_RST_HALF_CYC;
      r_r.irq_n     <= 1'b1;
      r_r.meas_mode <= `EACC_RST_BYTE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reg_rdata_o = r_r.rdata;
  assign zx_enable_o = r_r.zx_en;
  assign irq_n_o     = r_r.irq_n;

endmodule : eacc_top

// ==== test/eacc_asserts.sv ====
// port checker for the apparent energy accumulator
`timescale 1ns/10ps
`include "eacc_consts.svh"
module eacc_asserts (
  // clock and reset
  input wire logic                    mclk_i,
  input wire logic                    reset_n_i,
  // register port
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [`EACC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`EACC_E_W-1:0]    reg_wdata_i,
  input wire logic [`EACC_E_W-1:0]    reg_rdata_o,
  // line events
  input wire logic [2:0]              zero_cross_i,
  input wire logic [2:0]              zx_enable_o,
  input wire logic                    irq_n_o
);
  logic [3:0]  cnt_r;
  logic [15:0] hc_r;
  logic [1:0]  en_r;
  logic        hit;
  logic        wr_mm;
  logic        rd_e;
  logic        rd_st;
  logic [2:0]  wd_zx;
  assign hit   = |(zero_cross_i & zx_enable_o);
  assign wr_mm = reg_wr_i && reg_addr_i == `EACC_A_MEAS_MODE;
  assign rd_e  = reg_rd_i && reg_addr_i == `EACC_A_ENERGY;
  assign rd_st = reg_rd_i && reg_addr_i == `EACC_A_IRQ_ST;
  assign wd_zx = reg_wdata_i[6:4];
  // mirror of the tick phase and of two writable registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
      hc_r  <= 16'hFFFF;
      en_r  <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == 4'hB) ? 4'h0 : cnt_r + 4'h1;
      if (reg_wr_i && reg_addr_i == `EACC_A_HALF_CYC) hc_r <= reg_wdata_i[15:0];
      if (reg_wr_i && reg_addr_i == `EACC_A_IRQ_EN) en_r <= reg_wdata_i[1:0];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // a period end that is sure to be seen: count of one, flag enabled
  sequence s_end;
    hit && hc_r == 16'h0001 && en_r[1] && !reg_wr_i;
  endsequence
  sequence s_two_ends;
    s_end ##[1:300] s_end;
  endsequence
  sequence s_quiet_rd;
    rd_e && cnt_r != 4'hB && !reg_wr_i ##1 rd_e;
  endsequence
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  property p_hc_rd;
    reg_rd_i && reg_addr_i == `EACC_A_HALF_CYC && !reg_wr_i |=> reg_rdata_o == {8'h00, hc_r};
  endproperty
  property p_zx_map;
    wr_mm |=> zx_enable_o == $past(wd_zx);
  endproperty
  property p_zx_keep;
    !wr_mm |=> $stable(zx_enable_o);
  endproperty
  property p_tick;
    s_quiet_rd |=> $stable(reg_rdata_o);
  endproperty
  property p_irq_cause;
    $fell(irq_n_o) |-> en_r[0] || $past(hit) || $past(reg_wr_i);
  endproperty
  property p_line_end;
    s_two_ends |=> !irq_n_o;
  endproperty
  property p_flag;
    s_two_ends ##[1:4] rd_st |=> reg_rdata_o[`EACC_IRQ_LINE];
  endproperty
  a_hold:      assert property (p_hold) else $error("read data moved without a read");
  a_hc_rd:     assert property (p_hc_rd) else $error("half cycle count readback wrong");
  a_zx_map:    assert property (p_zx_map) else $error("phase enables not from mode bits");
  a_zx_keep:   assert property (p_zx_keep) else $error("phase enables moved");
  a_tick:      assert property (p_tick) else $error("energy moved off the tick");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  a_line_end:  assert property (p_line_end) else $error("period end without interrupt");
  a_flag:      assert property (p_flag) else $error("period flag not set");
endmodule : eacc_asserts

bind eacc_top eacc_asserts i_eacc_asserts (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .zero_cross_i(zero_cross_i),
  .zx_enable_o(zx_enable_o), .irq_n_o(irq_n_o));

// ==== test/tb.sv ====
// self-checking bench for the apparent energy accumulator
`timescale 1ns/10ps
`include "eacc_consts.svh"
module tb;
  logic                        mclk_i;
  logic                        reset_n_i;
  logic                        reg_wr_i;
  logic                        reg_rd_i;
  logic [`EACC_ADDR_W-1:0]     reg_addr_i;
  logic [`EACC_E_W-1:0]        reg_wdata_i;
  logic [`EACC_E_W-1:0]        reg_rdata_o;
  logic [2:0][`EACC_RMS_W-1:0] vrms_i;
  logic [2:0][`EACC_RMS_W-1:0] irms_i;
  logic [2:0][`EACC_PWR_W-1:0] active_pwr_i;
  logic [2:0][`EACC_PWR_W-1:0] reactive_pwr_i;
  logic [2:0]                  zero_cross_i;
  logic [2:0]                  zx_enable_o;
  logic                        irq_n_o;
  int                          err_total;
  int                          comparisons;
  logic [23:0]                 v;
  logic [23:0]                 w;
  // {mode register, divider, energy step per tick}
  logic [23:0]                 tab [8] = '{24'h010210, 24'h010120, 24'h010020, 24'h020008,
                                           24'h420010, 24'h820020, 24'hC20008, 24'h070028};

  eacc_top i_eacc_top (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .vrms_i(vrms_i), .irms_i(irms_i),
    .active_pwr_i(active_pwr_i), .reactive_pwr_i(reactive_pwr_i),
    .zero_cross_i(zero_cross_i), .zx_enable_o(zx_enable_o), .irq_n_o(irq_n_o));

  task automatic close_out;
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobes drop for a full cycle so back-to-back calls never re-drive in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = {16'h0000, d};
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
    @(negedge mclk_i);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d        = reg_rdata_o;
    @(negedge mclk_i);
  endtask : rd

  task automatic zc(input logic [2:0] m);
    zero_cross_i = m;
    @(negedge mclk_i);
    zero_cross_i = 3'h0;
    @(negedge mclk_i);
  endtask : zc

  task automatic t_reset;
    rd(`EACC_A_HALF_CYC, v);
    chk(v, 24'h00FFFF);
    rd(`EACC_A_WAV_MODE, v);
    chk(v, 24'h000000);
    rd(6'h3F, v);
    chk(v, 24'h000000);
    chk({20'h0, zx_enable_o, irq_n_o}, 24'h000001);
  endtask : t_reset

  // reads exactly 12 edges apart span one tick
  task automatic t_energy;
    for (int i = 0; i < 8; i++) begin
      wr(`EACC_A_VA_MODE, tab[i][23:16]);
      wr(`EACC_A_DIVIDER, tab[i][15:8]);
      rd(`EACC_A_ENERGY, v);
      repeat (10) @(negedge mclk_i);
      rd(`EACC_A_ENERGY, w);
      chk(w - v, {16'h0000, tab[i][7:0]});
    end
    rd(`EACC_A_ENERGY_RC, v);
    repeat (10) @(negedge mclk_i);
    rd(`EACC_A_ENERGY_RC, w);
    chk(w, 24'h000028);
    reg_rd_i   = 1'b1;
    reg_addr_i = `EACC_A_ENERGY;
    repeat (3) @(negedge mclk_i);
    reg_rd_i = 1'b0;
    @(negedge mclk_i);
  endtask : t_energy

  task automatic t_line;
    wr(`EACC_A_VA_MODE, 8'h09);
    wr(`EACC_A_IRQ_EN, 8'h02);
    wr(`EACC_A_HALF_CYC, 8'h02);
    wr(`EACC_A_MEAS_MODE, 8'h10);
    chk({21'h0, zx_enable_o}, 24'h000001);
    zc(3'b010);
    zc(3'b001);
    chk({23'h0, irq_n_o}, 24'h000001);
    zc(3'b001);
    chk({23'h0, irq_n_o}, 24'h000000);
    rd(`EACC_A_IRQ_ST, v);
    chk({23'h0, v[1]}, 24'h000001);
    chk({23'h0, irq_n_o}, 24'h000001);
    zc(3'b001);
    repeat (18) @(negedge mclk_i);
    zc(3'b001);
    chk({23'h0, irq_n_o}, 24'h000000);
    rd(`EACC_A_LINE_VA, v);
    chk(v, 24'h000040);
  endtask : t_line

  // 24 ticks of a power of 2^23 reads 6 unsigned, -6 signed
  task automatic t_react;
    active_pwr_i[0]   = 24'h800000;
    reactive_pwr_i[0] = 24'h800000;
    // status is still set by the line scenario; clear it so the checks below can fail
    rd(`EACC_A_IRQ_ST, v);
    chk({23'h0, irq_n_o}, 24'h000001);
    wr(`EACC_A_WAV_MODE, 8'h20);
    wr(`EACC_A_WAT_MODE, 8'h08);
    wr(`EACC_A_VA_MODE, 8'h01);
    wr(`EACC_A_HALF_CYC, 8'h01);
    zc(3'b001);
    chk({23'h0, irq_n_o}, 24'h000000);
    rd(`EACC_A_IRQ_ST, v);
    chk({23'h0, v[1]}, 24'h000001);
    repeat (284) @(negedge mclk_i);
    zc(3'b001);
    rd(`EACC_A_IRQ_ST, v);
    chk({23'h0, v[1]}, 24'h000001);
    rd(`EACC_A_LINE_VA, v);
    chk(v, 24'h000006);
    rd(`EACC_A_LINE_W, v);
    chk(v, 24'hFFFFFA);
  endtask : t_react

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  initial begin
    #40000;
    err_total++;
    close_out();
  end

  initial begin
    reset_n_i      = 1'b0;
    reg_wr_i       = 1'b0;
    reg_rd_i       = 1'b0;
    reg_addr_i     = 6'h00;
    reg_wdata_i    = 24'h000000;
    vrms_i         = {16'h0000, 16'h2000, 16'h8000};
    irms_i         = {16'h8000, 16'h8000, 16'h8000};
    active_pwr_i   = '0;
    reactive_pwr_i = '0;
    zero_cross_i   = 3'h0;
    err_total      = 0;
    comparisons    = 0;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_n_i = 1'b1;
    @(negedge mclk_i);
    t_reset();
    t_energy();
    t_line();
    t_react();
    close_out();
  end
endmodule : tb
